// ===== core/rcalp_top.sv
`timescale 1ns/1ps
module rcalp_top #(
   parameter logic [12:0] SMR_LONG_CYC = rcalp_pkg::RCALP_SMR_LONG_CYC
) (
   // Clock and reset.
   input wire logic clk,
   input wire logic resetn,
   // Avalon-MM register slave.
   input wire logic [11:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   // Watchdog control write port.
   output logic wdt_ctrl_wr,
   output logic [7:0] wdt_ctrl_data,
   // CPU and event sources on the system clock.
   input wire logic stop_instr,
   input wire logic halt_instr,
   input wire logic irq_pending,
   input wire logic wdt_timeout,
   input wire logic wdt_reset_mode,
   input wire logic bod_reset,
   input wire logic debug_reset_req,
   input wire logic debug_pin_break,
   input wire logic smr_pin_change,
   input wire logic bod_stop_option,
   // External reset pin.
   input wire logic ext_reset_pin_n,
   // Power and reset controls.
   output rcalp_pkg::rcalp_pwr_t pwr,
   output logic cpu_reset_hold,
   output logic sys_reset_out,
   output rcalp_pkg::rcalp_mode_t mode
);
   import rcalp_pkg::*;

   rcalp_mode_t state_r;
   rcalp_mode_t state_nxt;
   rcalp_flags_t flags_r;
   rcalp_flags_t flags_nxt;
   rcalp_osc_t osc_r;
   rcalp_osc_t osc_nxt;
   rcalp_pwr_t pwr_r;
   rcalp_pwr_t pwr_nxt;
   logic [7:0] periph_dis_r;
   logic [12:0] cnt_r;
   logic [12:0] cnt_nxt;
   logic [31:0] readdata_r;
   logic [31:0] rd_mux;
   logic wait_r;
   logic wdt_wr_r;
   logic [7:0] wdt_data_r;
   logic hold_r;
   logic sysrst_r;
   logic [2:0] sync_r;
   logic ext_low_r;
   logic ext_assert;
   logic req;
   logic accept;
   logic sel_cause;
   logic sel_osc;
   logic sel_periph;
   logic sel_mode;
   logic [3:0] clr_mask;
   logic in_stop;
   logic hi_evt;
   logic smr_evt;
   logic rst_evt;

   ////////////////////////////////////////////////////////////////////////////
   // Bus decode and handshake: one wait cycle, then the answer.
   assign req = avs_read | avs_write;
   assign accept = req & ~wait_r;
   assign sel_cause = avs_address == RCALP_ADDR_RESET_CAUSE;
   assign sel_osc = avs_address == RCALP_ADDR_OSC_CTRL;
   assign sel_periph = avs_address == RCALP_ADDR_PERIPH_DIS;
   assign sel_mode = avs_address == RCALP_ADDR_MODE_STAT;

   always_comb
   begin
      rd_mux = RCALP_RDATA_RST;
      if (sel_cause)
      begin
         rd_mux[7:0] = {flags_r, RCALP_RESERVED_VAL};
      end
      else if (sel_osc)
      begin
         rd_mux[3:0] = osc_r;
      end
      else if (sel_periph)
      begin
         rd_mux[7:0] = periph_dis_r;
      end
      else if (sel_mode)
      begin
         rd_mux[1:0] = state_r;
      end
   end

   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         wait_r <= 1'b1;
      end
      else
      begin
         wait_r <= ~(req & wait_r);
      end
   end

   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         readdata_r <= RCALP_RDATA_RST;
      end
      else if (req & wait_r)
      begin
         readdata_r <= avs_read ? rd_mux : RCALP_RDATA_RST;
      end
   end

   // Only bits actually delivered are cleared, so a later set survives.
   assign clr_mask = (accept & avs_read & sel_cause) ? readdata_r[7:4] : RCALP_RESERVED_VAL;

   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         wdt_wr_r <= 1'b0;
         wdt_data_r <= 8'h00;
      end
      else
      begin
         wdt_wr_r <= accept & avs_write & sel_cause & avs_byteenable[0];
         if (accept & avs_write & sel_cause & avs_byteenable[0])
         begin
            wdt_data_r <= avs_writedata[7:0];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // External reset pin synchroniser; a level counts once stages two and three agree.
   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         sync_r <= RCALP_SYNC_RST;
         ext_low_r <= 1'b0;
      end
      else
      begin
         sync_r <= {sync_r[1:0], ext_reset_pin_n};
         if (sync_r[1] == sync_r[2])
         begin
            ext_low_r <= ~sync_r[2];
         end
      end
   end

   assign ext_assert = (sync_r[1] == sync_r[2]) & ~sync_r[2] & ~ext_low_r;

   ////////////////////////////////////////////////////////////////////////////
   // Event classification.
   assign in_stop = state_r == RCALP_STOP;
   assign hi_evt = debug_reset_req | bod_reset | ext_assert | (debug_pin_break & in_stop);
   assign smr_evt = in_stop & (wdt_timeout | smr_pin_change);
   assign rst_evt = hi_evt | ext_low_r | (wdt_timeout & wdt_reset_mode & ~in_stop);

   ////////////////////////////////////////////////////////////////////////////
   // Reset-cause flags; a new event wins over a read clear in the same cycle.
   always_comb
   begin
      flags_nxt = flags_r & ~clr_mask;
      if (debug_reset_req | bod_reset | (debug_pin_break & in_stop))
      begin
         flags_nxt = RCALP_FLAGS_POR;
      end
      else if (ext_assert)
      begin
         flags_nxt = RCALP_FLAGS_EXT;
      end
      else if (wdt_timeout & in_stop)
      begin
         flags_nxt.por = 1'b0;
         flags_nxt.stop = 1'b1;
         flags_nxt.wdt = 1'b1;
      end
      else if (wdt_timeout)
      begin
         flags_nxt.por = 1'b0;
         flags_nxt.stop = 1'b0;
         flags_nxt.wdt = 1'b1;
      end
      else if (smr_pin_change & in_stop)
      begin
         flags_nxt = RCALP_FLAGS_PIN_SMR;
      end
   end

   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         flags_r <= RCALP_FLAGS_POR;
      end
      else
      begin
         flags_r <= flags_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Oscillator control and peripheral disable registers.
   always_comb
   begin
      osc_nxt = osc_r;
      if (accept & avs_write & sel_osc & avs_byteenable[0])
      begin
         osc_nxt = avs_writedata[3:0];
      end
      if (smr_evt & ~hi_evt)
      begin
         osc_nxt.clk_sel_xtal = 1'b0;
      end
   end

   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         osc_r <= RCALP_OSC_RST;
         periph_dis_r <= RCALP_PERIPH_DIS_RST;
      end
      else
      begin
         osc_r <= osc_nxt;
         if (accept & avs_write & sel_periph & avs_byteenable[0])
         begin
            periph_dis_r <= avs_writedata[7:0];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Power mode state machine.
   always_comb
   begin
      state_nxt = state_r;
      cnt_nxt = cnt_r;
      case (state_r)
         RCALP_RUN:
         begin
            if (stop_instr & ~rst_evt)
            begin
               state_nxt = RCALP_STOP;
            end
            else if (halt_instr & ~rst_evt)
            begin
               state_nxt = RCALP_HALT;
            end
         end
         RCALP_HALT:
         begin
            if (irq_pending | wdt_timeout | rst_evt)
            begin
               state_nxt = RCALP_RUN;
            end
         end
         RCALP_STOP:
         begin
            if (hi_evt)
            begin
               state_nxt = RCALP_RUN;
            end
            else if (smr_evt)
            begin
               state_nxt = RCALP_RECOVER;
               cnt_nxt = (osc_r.xtal_en ? SMR_LONG_CYC : RCALP_SMR_SHORT_CYC) - RCALP_CNT_ONE;
            end
         end
         RCALP_RECOVER:
         begin
            if (hi_evt | (cnt_r == RCALP_CNT_ZERO))
            begin
               state_nxt = RCALP_RUN;
            end
            else
            begin
               cnt_nxt = cnt_r - RCALP_CNT_ONE;
            end
         end
         default:
         begin
            state_nxt = RCALP_RUN;
         end
      endcase
   end

   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         state_r <= RCALP_RUN;
         cnt_r <= RCALP_CNT_ZERO;
      end
      else
      begin
         state_r <= state_nxt;
         cnt_r <= cnt_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Clock, oscillator and peripheral enables for the coming state.
   always_comb
   begin
      pwr_nxt.cpu_clk_en = state_nxt == RCALP_RUN;
      pwr_nxt.sys_clk_en = 1'b1;
      pwr_nxt.ipo_en = 1'b1;
      pwr_nxt.xtal_en = osc_nxt.xtal_en;
      pwr_nxt.xtal_pins_en = osc_nxt.xtal_en;
      pwr_nxt.clk_sel_xtal = osc_nxt.clk_sel_xtal;
      pwr_nxt.wdt_osc_en = osc_nxt.wdt_osc_en;
      pwr_nxt.wdt_run_en = osc_nxt.wdt_en;
      pwr_nxt.bod_en = 1'b1;
      pwr_nxt.periph_en = ~periph_dis_r;
      if (accept & avs_write & sel_periph & avs_byteenable[0])
      begin
         pwr_nxt.periph_en = ~avs_writedata[7:0];
      end
      if (state_nxt == RCALP_STOP)
      begin
         pwr_nxt.sys_clk_en = 1'b0;
         pwr_nxt.ipo_en = 1'b0;
         pwr_nxt.xtal_en = 1'b0;
         pwr_nxt.xtal_pins_en = 1'b0;
         pwr_nxt.clk_sel_xtal = 1'b0;
         pwr_nxt.bod_en = bod_stop_option;
         pwr_nxt.periph_en = 8'h00;
      end
   end

   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         pwr_r <= '0;
         hold_r <= 1'b0;
         sysrst_r <= 1'b0;
      end
      else
      begin
         pwr_r <= pwr_nxt;
         hold_r <= state_nxt == RCALP_RECOVER;
         sysrst_r <= rst_evt;
      end
   end

   assign avs_readdata = readdata_r;
   assign avs_waitrequest = wait_r;
   assign wdt_ctrl_wr = wdt_wr_r;
   assign wdt_ctrl_data = wdt_data_r;
   assign pwr = pwr_r;
   assign cpu_reset_hold = hold_r;
   assign sys_reset_out = sysrst_r;
   assign mode = state_r;

   ////////////////////////////////////////////////////////////////////////////
   // Checks.
   default clocking chk_cb @(posedge clk);
   endclocking
   default disable iff (!resetn);

   logic [12:0] hold_len_r;
   logic hold_xtal_r;

   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         hold_len_r <= RCALP_CNT_ZERO;
         hold_xtal_r <= 1'b0;
      end
      else
      begin
         hold_len_r <= hold_r ? hold_len_r + RCALP_CNT_ONE : RCALP_CNT_ZERO;
         if (!hold_r)
         begin
            hold_xtal_r <= osc_r.xtal_en;
         end
      end
   end

   sequence seq_cause_read;
      avs_read & sel_cause & wait_r ##1 avs_read & sel_cause & ~wait_r;
   endsequence

   sequence seq_stop_wdt;
      in_stop & wdt_timeout & ~hi_evt;
   endsequence

   chk_read_value: assert property (avs_read & sel_cause & wait_r |=>
      avs_readdata[7:4] == $past(flags_r))
      else $error("Reset-cause read did not return the flags before the read.");

   chk_read_clears: assert property (seq_cause_read ##0 ~hi_evt & ~wdt_timeout & ~smr_pin_change
      |=> (flags_r & $past(readdata_r[7:4])) == 4'h0)
      else $error("Reset-cause read did not clear the delivered flags.");

   chk_reserved_zero: assert property (avs_read & sel_cause & ~wait_r |-> avs_readdata[3:0] == 4'h0)
      else $error("Reserved reset-cause bits did not read as zero.");

   chk_wdt_write: assert property (avs_write & sel_cause & ~wait_r & avs_byteenable[0] |=>
      wdt_ctrl_wr && wdt_ctrl_data == $past(avs_writedata[7:0]) && flags_r == $past(flags_nxt))
      else $error("Write at the shared address did not reach watchdog control.");

   chk_ext_flag: assert property (ext_assert & ~debug_reset_req & ~bod_reset & ~(debug_pin_break & in_stop)
      |=> flags_r == 4'h1 ##1 sys_reset_out)
      else $error("Reset pin did not leave only the external flag set.");

   chk_dbg_por: assert property (debug_reset_req |=> flags_r == 4'h8 && sys_reset_out)
      else $error("Debugger reset did not leave power-on flags.");

   chk_dbg_pin_stop: assert property (debug_pin_break & in_stop |=> flags_r == 4'h8 && mode == RCALP_RUN)
      else $error("Debug pin in stop did not set only the power-on flag.");

   chk_wdt_stop: assert property (seq_stop_wdt |=> flags_r.stop && flags_r.wdt && !flags_r.por
      && mode == RCALP_RECOVER && cpu_reset_hold)
      else $error("Watchdog recovery did not set stop and watchdog flags.");

   chk_wdt_run: assert property (wdt_timeout & ~in_stop & ~hi_evt |=> !flags_r.por && !flags_r.stop && flags_r.wdt)
      else $error("Watchdog time-out in run did not update the flags.");

   chk_pin_recover: assert property (in_stop & smr_pin_change & ~wdt_timeout & ~hi_evt
      |=> flags_r == 4'h4 && mode == RCALP_RECOVER)
      else $error("Pin recovery did not leave only the stop flag set.");

   chk_stop_outputs: assert property (mode == RCALP_STOP |-> !pwr.cpu_clk_en && !pwr.sys_clk_en
      && !pwr.ipo_en && !pwr.xtal_en && !pwr.xtal_pins_en && pwr.periph_en == 8'h00
      && pwr.bod_en == $past(bod_stop_option))
      else $error("Stop mode left a clock, pin or peripheral running.");

   chk_halt_outputs: assert property (mode == RCALP_HALT |-> !pwr.cpu_clk_en && pwr.sys_clk_en
      && pwr.ipo_en && pwr.wdt_run_en == osc_r.wdt_en)
      else $error("Halt mode changed something besides the CPU clock.");

   chk_halt_exit: assert property (mode == RCALP_HALT & (irq_pending | wdt_timeout) |=> mode == RCALP_RUN
      && pwr.cpu_clk_en)
      else $error("Halt was not left on interrupt or watchdog.");

   chk_stop_stays: assert property (in_stop & ~smr_evt & ~hi_evt |=> mode == RCALP_STOP)
      else $error("Stop mode was left without a recovery event.");

   chk_recover_len: assert property ($fell(cpu_reset_hold) & ~$past(hi_evt) |->
      hold_len_r == (hold_xtal_r ? SMR_LONG_CYC : RCALP_SMR_SHORT_CYC))
      else $error("Recovery reset hold had the wrong length.");

   chk_smr_ipo: assert property ($rose(mode == RCALP_RECOVER) |-> !osc_r.clk_sel_xtal && pwr.ipo_en
      && periph_dis_r == $past(periph_dis_r))
      else $error("Recovery did not select the internal oscillator.");

   chk_periph_dis: assert property (mode == RCALP_RUN && $past(resetn)
      |-> pwr.periph_en == ~periph_dis_r)
      else $error("Peripheral enables do not follow the disable register.");

endmodule // rcalp_top

// ===== core/rcalp_pkg.sv
package rcalp_pkg;

   ////////////////////////////////////////////////////////////////////////////
   // Register byte addresses on the bus.
   localparam logic [11:0] RCALP_ADDR_RESET_CAUSE = 12'hFF0;
   localparam logic [11:0] RCALP_ADDR_OSC_CTRL = 12'hF84;
   localparam logic [11:0] RCALP_ADDR_PERIPH_DIS = 12'hF88;
   localparam logic [11:0] RCALP_ADDR_MODE_STAT = 12'hF8C;

   ////////////////////////////////////////////////////////////////////////////
   // Reset-cause flag field: bits 7 down to 4 of the status byte.
   localparam int RCALP_FLAGS_LSB = 4;
   localparam logic [3:0] RCALP_FLAGS_POR = 4'h8;
   localparam logic [3:0] RCALP_FLAGS_EXT = 4'h1;
   localparam logic [3:0] RCALP_FLAGS_PIN_SMR = 4'h4;
   localparam logic [3:0] RCALP_RESERVED_VAL = 4'h0;

   ////////////////////////////////////////////////////////////////////////////
   // Values after reset.
   localparam logic [3:0] RCALP_OSC_RST = 4'h0;
   localparam logic [7:0] RCALP_PERIPH_DIS_RST = 8'h00;
   localparam logic [31:0] RCALP_RDATA_RST = 32'h0000_0000;
   localparam logic [2:0] RCALP_SYNC_RST = 3'h7;

   ////////////////////////////////////////////////////////////////////////////
   // Stop-mode recovery hold counts in oscillator cycles.
   localparam logic [12:0] RCALP_SMR_SHORT_CYC = 13'h0042;
   localparam logic [12:0] RCALP_SMR_LONG_CYC = 13'h1388;
   localparam logic [12:0] RCALP_CNT_ONE = 13'h0001;
   localparam logic [12:0] RCALP_CNT_ZERO = 13'h0000;

   ////////////////////////////////////////////////////////////////////////////
   // Types.
   typedef enum logic [1:0] {
      RCALP_RUN = 2'b00,
      RCALP_HALT = 2'b01,
      RCALP_STOP = 2'b10,
      RCALP_RECOVER = 2'b11
   } rcalp_mode_t;

   typedef struct packed {
      logic por;
      logic stop;
      logic wdt;
      logic external_reset_flag;
   } rcalp_flags_t;

   typedef struct packed {
      logic xtal_en;
      logic clk_sel_xtal;
      logic wdt_osc_en;
      logic wdt_en;
   } rcalp_osc_t;

   typedef struct packed {
      logic cpu_clk_en;
      logic sys_clk_en;
      logic ipo_en;
      logic xtal_en;
      logic xtal_pins_en;
      logic clk_sel_xtal;
      logic wdt_osc_en;
      logic wdt_run_en;
      logic bod_en;
      logic [7:0] periph_en;
   } rcalp_pwr_t;

endpackage

// ===== verif/rcalp_tb.sv
`timescale 1ns/1ps
module tb;
   import rcalp_pkg::*;
   localparam logic [12:0] LONG_CYC = 13'h0014;
   localparam int E_STOP = 0;
   localparam int E_HALT = 1;
   localparam int E_WDT = 2;
   localparam int E_BOD = 3;
   localparam int E_DBGR = 4;
   localparam int E_DBGP = 5;
   localparam int E_PIN = 6;
   logic clk = 1'b0;
   logic resetn = 1'b0;
   logic [11:0] avs_address = 12'h000;
   logic avs_read = 1'b0;
   logic avs_write = 1'b0;
   logic [31:0] avs_writedata = 32'h0;
   logic [3:0] avs_byteenable = 4'h1;
   logic [31:0] avs_readdata;
   logic avs_waitrequest;
   logic wdt_ctrl_wr;
   logic [7:0] wdt_ctrl_data;
   logic stop_instr = 1'b0;
   logic halt_instr = 1'b0;
   logic irq_pending = 1'b0;
   logic wdt_timeout = 1'b0;
   logic wdt_reset_mode = 1'b0;
   logic bod_reset = 1'b0;
   logic debug_reset_req = 1'b0;
   logic debug_pin_break = 1'b0;
   logic smr_pin_change = 1'b0;
   logic bod_stop_option = 1'b1;
   logic ext_reset_pin_n = 1'b1;
   rcalp_pwr_t pwr;
   logic cpu_reset_hold;
   logic sys_reset_out;
   rcalp_mode_t mode;
   int bad_count = 0;
   int checks = 0;
   int n;
   ////////////////////////////////////////////////////////////////////////////
   // Design under test with a short long-hold count.
   rcalp_top #(.SMR_LONG_CYC(LONG_CYC)) i_rcalp_top (.clk(clk), .resetn(resetn), .avs_address(avs_address),
      .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
      .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .wdt_ctrl_wr(wdt_ctrl_wr),
      .wdt_ctrl_data(wdt_ctrl_data), .stop_instr(stop_instr), .halt_instr(halt_instr), .irq_pending(irq_pending),
      .wdt_timeout(wdt_timeout), .wdt_reset_mode(wdt_reset_mode), .bod_reset(bod_reset),
      .debug_reset_req(debug_reset_req), .debug_pin_break(debug_pin_break), .smr_pin_change(smr_pin_change),
      .bod_stop_option(bod_stop_option), .ext_reset_pin_n(ext_reset_pin_n), .pwr(pwr),
      .cpu_reset_hold(cpu_reset_hold), .sys_reset_out(sys_reset_out), .mode(mode));
   always #20 clk = ~clk;
   ////////////////////////////////////////////////////////////////////////////
   // Checking and closing.
   task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp)
      begin
         bad_count++;
         $display("[ERR] %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task automatic complete_run();
      if (bad_count == 0 && checks > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////////
   // Bus cycles: hold the request until waitrequest is sampled low.
   task automatic xfer(input logic wr, input logic [11:0] addr, input logic [31:0] wdata, output logic [31:0] rdata);
      int i;
      @(posedge clk);
      avs_address <= addr;
      avs_writedata <= wdata;
      if (wr)
         avs_write <= 1'b1;
      else
         avs_read <= 1'b1;
      i = 1;
      @(posedge clk);
      while (avs_waitrequest !== 1'b0)
      begin
         @(posedge clk);
         i++;
      end
      rdata = avs_readdata;
      chk("answer edges", i, 32'd2);
      avs_read <= 1'b0;
      avs_write <= 1'b0;
   endtask
   task automatic rd(input logic [11:0] addr, input logic [31:0] exp, input string name);
      logic [31:0] d;
      xfer(1'b0, addr, 32'h0, d);
      chk(name, d, exp);
   endtask
   task automatic wr(input logic [11:0] addr, input logic [31:0] data);
      logic [31:0] d;
      xfer(1'b1, addr, data, d);
   endtask
   ////////////////////////////////////////////////////////////////////////////
   // One-cycle event pulses and recovery hold measurement.
   task automatic ev_now(input int k);
      @(posedge clk);
      case (k)
         E_STOP: stop_instr <= 1'b1;
         E_HALT: halt_instr <= 1'b1;
         E_WDT: wdt_timeout <= 1'b1;
         E_BOD: bod_reset <= 1'b1;
         E_DBGR: debug_reset_req <= 1'b1;
         E_DBGP: debug_pin_break <= 1'b1;
         default: smr_pin_change <= 1'b1;
      endcase
      @(posedge clk);
      {stop_instr, halt_instr, wdt_timeout, bod_reset, debug_reset_req, debug_pin_break, smr_pin_change} <= 7'h00;
   endtask
   task automatic ev(input int k);
      ev_now(k);
      repeat (3) @(posedge clk);
   endtask
   task automatic hold_len(output int cnt);
      int i;
      cnt = 0;
      for (i = 0; i < 6000; i++)
      begin
         @(posedge clk);
         if (cpu_reset_hold === 1'b1)
            cnt++;
         else if (cnt > 0 || mode === RCALP_RUN)
            break;
      end
   endtask
   ////////////////////////////////////////////////////////////////////////////
   // Tests.
   initial
   begin
      repeat (5) @(posedge clk);
      resetn <= 1'b1;
      rd(RCALP_ADDR_RESET_CAUSE, 32'h80, "por flags");
      rd(RCALP_ADDR_RESET_CAUSE, 32'h00, "cleared flags");
      wr(RCALP_ADDR_RESET_CAUSE, 32'h50);
      #1 chk("wdt ctrl wr", {31'h0, wdt_ctrl_wr}, 32'h1);
      chk("wdt ctrl data", {24'h0, wdt_ctrl_data}, 32'h50);
      rd(RCALP_ADDR_RESET_CAUSE, 32'h00, "flags after write");
      ev(E_DBGR);
      rd(RCALP_ADDR_RESET_CAUSE, 32'h80, "debugger reset");
      ev(E_DBGR);
      ev(E_WDT);
      rd(RCALP_ADDR_RESET_CAUSE, 32'h20, "run watchdog");
      ev(E_PIN);
      rd(RCALP_ADDR_RESET_CAUSE, 32'h00, "pin outside stop");
      // Stop, then recovery from a pin change with the short hold.
      ev(E_STOP);
      chk("stop mode", {30'h0, mode}, {30'h0, RCALP_STOP});
      chk("stop pwr", {15'h0, pwr}, 32'h0100);
      ev_now(E_PIN);
      hold_len(n);
      chk("short hold", n, 32'd66);
      chk("run after smr", {30'h0, mode}, {30'h0, RCALP_RUN});
      rd(RCALP_ADDR_RESET_CAUSE, 32'h40, "pin recovery");
      // Stop with crystal and watchdog oscillator, recovery by watchdog.
      wr(RCALP_ADDR_OSC_CTRL, 32'h0F);
      rd(RCALP_ADDR_OSC_CTRL, 32'h0F, "osc ctrl");
      ev(E_STOP);
      chk("stop pwr wdt", {15'h0, pwr}, 32'h0700);
      ev_now(E_WDT);
      hold_len(n);
      chk("long hold", n, {19'h0, LONG_CYC});
      rd(RCALP_ADDR_RESET_CAUSE, 32'h60, "wdt recovery");
      rd(RCALP_ADDR_OSC_CTRL, 32'h0B, "osc after smr");
      bod_stop_option <= 1'b0;
      wr(RCALP_ADDR_OSC_CTRL, 32'h00);
      ev(E_STOP);
      chk("stop pwr nobod", {15'h0, pwr}, 32'h0000);
      ev(E_DBGP);
      rd(RCALP_ADDR_RESET_CAUSE, 32'h80, "debug pin stop");
      // Halt and its exits.
      ev(E_HALT);
      chk("halt mode", {30'h0, mode}, {30'h0, RCALP_HALT});
      chk("halt clocks", {29'h0, pwr.cpu_clk_en, pwr.sys_clk_en, pwr.ipo_en}, 32'h3);
      rd(RCALP_ADDR_MODE_STAT, 32'h1, "mode reg halt");
      irq_pending <= 1'b1;
      repeat (3) @(posedge clk);
      irq_pending <= 1'b0;
      chk("irq exit", {30'h0, mode}, {30'h0, RCALP_RUN});
      ev(E_HALT);
      ev(E_WDT);
      chk("wdt exit", {30'h0, mode}, {30'h0, RCALP_RUN});
      wdt_reset_mode <= 1'b1;
      ev(E_HALT);
      ev(E_WDT);
      chk("wdt reset exit", {30'h0, mode}, {30'h0, RCALP_RUN});
      wdt_reset_mode <= 1'b0;
      ev(E_HALT);
      ev(E_BOD);
      chk("bod exit", {30'h0, mode}, {30'h0, RCALP_RUN});
      rd(RCALP_ADDR_RESET_CAUSE, 32'h80, "bod flags");
      // External reset pin, then pin recovery clears it.
      ev(E_HALT);
      @(posedge clk);
      ext_reset_pin_n <= 1'b0;
      repeat (8) @(posedge clk);
      chk("sys reset held", {31'h0, sys_reset_out}, 32'h1);
      ext_reset_pin_n <= 1'b1;
      repeat (8) @(posedge clk);
      chk("pin exit", {30'h0, mode}, {30'h0, RCALP_RUN});
      rd(RCALP_ADDR_RESET_CAUSE, 32'h10, "ext flags");
      ext_reset_pin_n <= 1'b0;
      repeat (8) @(posedge clk);
      ext_reset_pin_n <= 1'b1;
      repeat (8) @(posedge clk);
      ev(E_STOP);
      ev(E_PIN);
      hold_len(n);
      rd(RCALP_ADDR_RESET_CAUSE, 32'h40, "pin clears ext");
      // Peripheral disable and unmapped access.
      wr(RCALP_ADDR_PERIPH_DIS, 32'h05);
      rd(RCALP_ADDR_PERIPH_DIS, 32'h05, "periph dis");
      #1 chk("periph en", {24'h0, pwr.periph_en}, 32'hFA);
      rd(12'h100, 32'h00, "unmapped");
      // Power-on again in mid-run.
      @(posedge clk);
      resetn <= 1'b0;
      repeat (5) @(posedge clk);
      resetn <= 1'b1;
      rd(RCALP_ADDR_RESET_CAUSE, 32'h80, "second por");
      rd(RCALP_ADDR_PERIPH_DIS, 32'h00, "periph reset");
      complete_run();
   end
   initial
   begin
      #2000000;
      bad_count++;
      complete_run();
   end
endmodule // tb
